// ### design/wsmu_core.sv
// word shift and move unit: sequences digit shifts, shift register, copies and fills
// assumes memory answers a read one cycle after o_mem_rd
// Notes on behaviour
// - condition off: nothing changes
// - digit left: zero into first, last top digit lost
// - digit right: zero into first top, last low lost
// - digit shifts fault on split or reversed range
// - one steering word gives direction, input, pulse, reset
// - shift register over one or many words, either way
// - carry takes first bit 00 or last bit 15
// - shift register faults on split or reversed range
// - copy writes source or constant unchanged
// - inverted copy writes its complement
// - copies set zero flag on all-zero result
// - timer or counter copy targets refused
// - block copy moves count words in order
// - block copy faults on non-bcd count or block leaving area
// - fill writes source first to last, faults on split or reversed
// - fill may write timer and counter present values
// - bad indirect pointers raise the fault flag
// - only destinations written, sources only read
`timescale 1ns/10ps
`default_nettype none
module wsmu_core import wsmu_pkg::*; (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_start,
  input  wire logic        i_exec_cond,
  input  wire logic [7:0]  i_func,
  input  wire logic [2:0]  i_opd_a_area,
  input  wire logic [9:0]  i_opd_a_off,
  input  wire logic        i_opd_a_ind,
  input  wire logic        i_opd_a_is_const,
  input  wire logic [15:0] i_opd_a_const,
  input  wire logic [2:0]  i_opd_b_area,
  input  wire logic [9:0]  i_opd_b_off,
  input  wire logic        i_opd_b_ind,
  input  wire logic [2:0]  i_opd_c_area,
  input  wire logic [9:0]  i_opd_c_off,
  input  wire logic        i_opd_c_ind,
  input  wire logic [15:0] i_mem_rdata,
  output logic             o_busy,
  output logic             o_done,
  output logic             o_mem_rd,
  output logic             o_mem_wr,
  output logic [2:0]       o_mem_area,
  output logic [9:0]       o_mem_off,
  output logic [15:0]      o_mem_wdata,
  output logic             o_fault_flag,
  output logic             o_carry_bit,
  output logic             o_zero_result_flag
);
  wsmu_state_t state;
  logic [7:0]  func;
  logic [2:0]  op_area [0:2];
  logic [9:0]  op_off  [0:2];
  logic [2:0]  op_ind;
  logic        a_is_const;
  logic [15:0] a_val;
  logic [1:0]  k;
  logic [13:0] idx;
  logic [13:0] len;
  logic        dir_down;
  logic        rd_needed;
  logic        reversible_shift_register_shift;
  logic [1:0]  alu_mode;
  logic [3:0]  carry;

  wire logic        fn_known;
  wire logic        use_a;
  wire logic        is_block_copy;
  wire logic [2:0]  ok;
  wire logic [13:0] n_bin;
  wire logic        n_bcd;
  wire logic [13:0] ext;
  wire logic [13:0] range_len;
  wire logic        range_bad, block_copy_bad, copy_bad, chk_err;
  wire logic        ptr_addr_ok;
  wire logic        ptr_ok;
  wire logic        ind_now;
  wire logic        last_step;
  wire logic [9:0]  idx10;
  wire logic [9:0]  seq_off;
  wire logic [9:0]  rd_off;
  wire logic [9:0]  wr_off;
  wire logic [2:0]  wr_area;
  wire logic [15:0] alu_word;
  wire logic [3:0]  alu_carry;
  wire logic        steer_reset, steer_pulse, steer_left, steer_in;

  assign fn_known = (i_func == FN_WORD_COPY) || (i_func == FN_WORD_COPY_INVERTED) || (i_func == FN_BLOCK_COPY)
                 || (i_func == FN_BLOCK_FILL) || (i_func == FN_DIGIT_SHIFT_LEFT)
                 || (i_func == FN_DIGIT_SHIFT_RIGHT) || (i_func == FN_REV_SHIFT_REGISTER);
  assign use_a   = (func != FN_DIGIT_SHIFT_LEFT) && (func != FN_DIGIT_SHIFT_RIGHT);
  assign is_block_copy = (func == FN_BLOCK_COPY);

  // count trusted only once bcd
  assign n_bcd = wsmu_is_bcd(a_val);
  assign n_bin = wsmu_bcd_to_bin(a_val);
  assign ext   = (is_block_copy && n_bin != 14'h0000) ? n_bin - 14'h0001 : 14'h0000;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_rng
      wsmu_range_check u_chk (
        .i_area (op_area[g]),
        .i_off  (op_off[g]),
        .i_ext  ((g == 0) ? 14'h0000 : ext),
        .o_ok   (ok[g])
      );
    end
  endgenerate

  assign range_len = {4'h0, op_off[2]} - {4'h0, op_off[1]} + 14'h0001;
  assign range_bad = (op_area[1] != op_area[2]) || (op_off[1] > op_off[2]) || !ok[1] || !ok[2];
  assign block_copy_bad  = !n_bcd || ((n_bin != 14'h0000) && (!ok[1] || !ok[2]));
  assign copy_bad  = (op_area[1] == AREA_TC) || !ok[1];
  assign chk_err   = is_block_copy ? block_copy_bad
                   : ((func == FN_WORD_COPY) || (func == FN_WORD_COPY_INVERTED)) ? copy_bad
                   : range_bad;

  // pointer: bcd offset inside data memory
  assign ind_now     = (k != 2'h3) && op_ind[k];
  assign ptr_addr_ok = op_off[k] < WORDS_DM[9:0];
  assign ptr_ok      = wsmu_is_bcd(i_mem_rdata) && (wsmu_bcd_to_bin(i_mem_rdata) < WORDS_DM);

  assign steer_reset = a_val[STEER_RESET_BIT];
  assign steer_pulse = a_val[STEER_PULSE_BIT];
  assign steer_left  = a_val[STEER_DIR_BIT];
  assign steer_in    = a_val[STEER_IN_BIT];

  assign idx10     = idx[9:0];
  assign seq_off   = dir_down ? op_off[2] - idx10 : op_off[1] + idx10;
  // sources are only ever read
  assign rd_off    = seq_off;
  assign wr_off    = is_block_copy ? op_off[2] + idx10 : seq_off;
  assign wr_area   = is_block_copy ? op_area[2] : op_area[1];
  assign last_step = (idx == len - 14'h0001);

  assign o_mem_rd = (state == ST_IND_RD && ind_now && ptr_addr_ok)
                 || (state == ST_A_RD && use_a && !a_is_const && ok[0])
                 || (state == ST_RD);
  assign o_mem_wr = (state == ST_WR);
  assign o_mem_area = (state == ST_IND_RD) ? AREA_DM
                    : (state == ST_A_RD) ? op_area[0]
                    : (state == ST_WR) ? wr_area : op_area[1];
  assign o_mem_off  = (state == ST_IND_RD) ? op_off[k]
                    : (state == ST_A_RD) ? op_off[0]
                    : (state == ST_WR) ? wr_off : rd_off;
  assign o_busy = (state != ST_IDLE);
  assign o_done = (state == ST_DONE);

  wsmu_word_alu u_alu (
    .i_mode  (alu_mode),
    .i_word  (i_mem_rdata),
    .i_carry (carry),
    .o_word  (alu_word),
    .o_carry (alu_carry)
  );

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state              <= ST_IDLE;
      func               <= 8'h00;
      op_area            <= '{3'h0, 3'h0, 3'h0};
      op_off             <= '{10'h000, 10'h000, 10'h000};
      op_ind             <= 3'h0;
      a_is_const         <= 1'b0;
      a_val              <= 16'h0000;
      k                  <= 2'h0;
      idx                <= 14'h0000;
      len                <= 14'h0000;
      dir_down           <= 1'b0;
      rd_needed          <= 1'b0;
      reversible_shift_register_shift         <= 1'b0;
      alu_mode           <= ALU_DIGIT_LEFT;
      carry              <= 4'h0;
      o_mem_wdata        <= 16'h0000;
      o_fault_flag       <= 1'b0;
      o_carry_bit        <= 1'b0;
      o_zero_result_flag <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (i_start) begin
            // off or unknown code: no effect
            if (!i_exec_cond || !fn_known) begin
              state <= ST_DONE;
            end else begin
              func         <= i_func;
              op_area      <= '{i_opd_a_area, i_opd_b_area, i_opd_c_area};
              op_off       <= '{i_opd_a_off, i_opd_b_off, i_opd_c_off};
              op_ind       <= {i_opd_c_ind, i_opd_b_ind, i_opd_a_ind && !i_opd_a_is_const};
              a_is_const   <= i_opd_a_is_const;
              a_val        <= i_opd_a_const;
              k            <= 2'h0;
              reversible_shift_register_shift   <= 1'b0;
              o_fault_flag <= 1'b0;
              state        <= ST_IND_RD;
            end
          end
        end
        ST_IND_RD: begin
          if (k == 2'h3) begin
            state <= ST_A_RD;
          end else if (!op_ind[k]) begin
            k <= k + 2'h1;
          end else if (!ptr_addr_ok) begin
            o_fault_flag <= 1'b1;
            state        <= ST_DONE;
          end else begin
            state <= ST_IND_WT;
          end
        end
        ST_IND_WT: begin
          if (!ptr_ok) begin
            o_fault_flag <= 1'b1;
            state        <= ST_DONE;
          end else begin
            op_area[k] <= AREA_DM;
            op_off[k]  <= 10'(wsmu_bcd_to_bin(i_mem_rdata));
            k          <= k + 2'h1;
            state      <= ST_IND_RD;
          end
        end
        ST_A_RD: begin
          if (!use_a || a_is_const) begin
            state <= ST_CHECK;
          end else if (!ok[0]) begin
            o_fault_flag <= 1'b1;
            state        <= ST_DONE;
          end else begin
            state <= ST_A_WT;
          end
        end
        ST_A_WT: begin
          a_val <= i_mem_rdata;
          state <= ST_CHECK;
        end
        ST_CHECK: begin
          idx       <= 14'h0000;
          len       <= range_len;
          dir_down  <= 1'b0;
          rd_needed <= 1'b0;
          carry     <= 4'h0;
          if (chk_err) begin
            o_fault_flag <= 1'b1;
            state        <= ST_DONE;
          end else begin
            unique case (func)
              FN_DIGIT_SHIFT_LEFT: begin
                alu_mode  <= ALU_DIGIT_LEFT;
                rd_needed <= 1'b1;
                state     <= ST_RD;
              end
              FN_DIGIT_SHIFT_RIGHT: begin
                alu_mode  <= ALU_DIGIT_RIGHT;
                rd_needed <= 1'b1;
                state     <= ST_RD;
              end
              FN_REV_SHIFT_REGISTER: begin
                if (steer_reset) begin
                  o_mem_wdata <= 16'h0000;
                  state       <= ST_WR;
                end else if (steer_pulse) begin
                  // right walks last to first
                  alu_mode   <= steer_left ? ALU_BIT_LEFT : ALU_BIT_RIGHT;
                  dir_down   <= !steer_left;
                  carry      <= {3'h0, steer_in};
                  rd_needed  <= 1'b1;
                  reversible_shift_register_shift <= 1'b1;
                  state      <= ST_RD;
                end else begin
                  state <= ST_DONE;
                end
              end
              FN_WORD_COPY, FN_WORD_COPY_INVERTED: begin
                o_mem_wdata        <= (func == FN_WORD_COPY) ? a_val : ~a_val;
                o_zero_result_flag <= (func == FN_WORD_COPY) ? (a_val == 16'h0000) : (a_val == 16'hffff);
                len                <= 14'h0001;
                state              <= ST_WR;
              end
              FN_BLOCK_COPY: begin
                len       <= n_bin;
                rd_needed <= 1'b1;
                state     <= (n_bin == 14'h0000) ? ST_DONE : ST_RD;
              end
              FN_BLOCK_FILL: begin
                // timer area is a legal fill target
                o_mem_wdata <= a_val;
                state       <= ST_WR;
              end
              default: begin
                state <= ST_DONE;
              end
            endcase
          end
        end
        ST_RD: begin
          state <= ST_WT;
        end
        ST_WT: begin
          o_mem_wdata <= is_block_copy ? i_mem_rdata : alu_word;
          if (!is_block_copy) begin
            carry <= alu_carry;
          end
          state <= ST_WR;
        end
        ST_WR: begin
          if (last_step) begin
            if (reversible_shift_register_shift) begin
              o_carry_bit <= carry[0];
            end
            state <= ST_DONE;
          end else begin
            idx   <= idx + 14'h0001;
            state <= rd_needed ? ST_RD : ST_WR;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### design/wsmu_pkg.sv
// word shift and move unit: shared constants, area map, helpers
// assumes the controller data area is addressed as area code plus word offset
package wsmu_pkg;

  localparam int AREA_W = 3;
  localparam int OFF_W  = 10;
  localparam int EXT_W  = 14;

  // area codes and sizes
  localparam logic [2:0]  AREA_IR = 3'h0;
  localparam logic [2:0]  AREA_SR = 3'h1;
  localparam logic [2:0]  AREA_AR = 3'h2;
  localparam logic [2:0]  AREA_DM = 3'h3;
  localparam logic [2:0]  AREA_HR = 3'h4;
  localparam logic [2:0]  AREA_LR = 3'h5;
  localparam logic [2:0]  AREA_TC = 3'h6;
  localparam logic [13:0] WORDS_IR = 14'h0040;
  localparam logic [13:0] WORDS_SR = 14'h0008;
  localparam logic [13:0] WORDS_AR = 14'h0010;
  localparam logic [13:0] WORDS_DM = 14'h03e8;
  localparam logic [13:0] WORDS_HR = 14'h0064;
  localparam logic [13:0] WORDS_LR = 14'h0040;
  localparam logic [13:0] WORDS_TC = 14'h0200;

  // codes as hex of decimal digits
  localparam logic [7:0] FN_WORD_COPY          = 8'h21;
  localparam logic [7:0] FN_WORD_COPY_INVERTED = 8'h22;
  localparam logic [7:0] FN_BLOCK_COPY         = 8'h70;
  localparam logic [7:0] FN_BLOCK_FILL         = 8'h71;
  localparam logic [7:0] FN_DIGIT_SHIFT_LEFT   = 8'h74;
  localparam logic [7:0] FN_DIGIT_SHIFT_RIGHT  = 8'h75;
  localparam logic [7:0] FN_REV_SHIFT_REGISTER = 8'h84;

  // shift register steering bits
  localparam int STEER_DIR_BIT   = 12;
  localparam int STEER_IN_BIT    = 13;
  localparam int STEER_PULSE_BIT = 14;
  localparam int STEER_RESET_BIT = 15;

  // word alu modes
  localparam logic [1:0] ALU_DIGIT_LEFT  = 2'h0;
  localparam logic [1:0] ALU_DIGIT_RIGHT = 2'h1;
  localparam logic [1:0] ALU_BIT_LEFT    = 2'h2;
  localparam logic [1:0] ALU_BIT_RIGHT   = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_IND_RD = 4'h1,
    ST_IND_WT = 4'h2,
    ST_A_RD   = 4'h3,
    ST_A_WT   = 4'h4,
    ST_CHECK  = 4'h5,
    ST_RD     = 4'h6,
    ST_WT     = 4'h7,
    ST_WR     = 4'h8,
    ST_DONE   = 4'h9
  } wsmu_state_t;

  function automatic logic [13:0] wsmu_area_words(input logic [2:0] area);
    case (area)
      AREA_IR: wsmu_area_words = WORDS_IR;
      AREA_SR: wsmu_area_words = WORDS_SR;
      AREA_AR: wsmu_area_words = WORDS_AR;
      AREA_DM: wsmu_area_words = WORDS_DM;
      AREA_HR: wsmu_area_words = WORDS_HR;
      AREA_LR: wsmu_area_words = WORDS_LR;
      AREA_TC: wsmu_area_words = WORDS_TC;
      default: wsmu_area_words = 14'h0000;
    endcase
  endfunction

  function automatic logic wsmu_is_bcd(input logic [15:0] w);
    wsmu_is_bcd = (w[15:12] < 4'ha) && (w[11:8] < 4'ha) && (w[7:4] < 4'ha) && (w[3:0] < 4'ha);
  endfunction

  function automatic logic [13:0] wsmu_bcd_to_bin(input logic [15:0] w);
    wsmu_bcd_to_bin = 14'({10'h000, w[15:12]} * 14'd1000) + 14'({10'h000, w[11:8]} * 14'd100)
                    + 14'({10'h000, w[7:4]} * 14'd10) + {10'h000, w[3:0]};
  endfunction

endpackage

// ### design/wsmu_range_check.sv
// word shift and move unit: checks that a block of words fits inside one area
// assumes offset and extent are already resolved to plain binary
`timescale 1ns/10ps
`default_nettype none
module wsmu_range_check import wsmu_pkg::*; (
  input  wire logic [2:0]  i_area,
  input  wire logic [9:0]  i_off,
  input  wire logic [13:0] i_ext,
  output logic             o_ok
);
  wire logic [14:0] last_word;

  // spare bit stops a wrap into range
  assign last_word = {5'h00, i_off} + {1'b0, i_ext};
  assign o_ok      = last_word < {1'b0, wsmu_area_words(i_area)};
endmodule
`default_nettype wire

// ### design/wsmu_word_alu.sv
// word shift and move unit: one-word digit and bit shifter with carry in and out
// assumes the caller chains carries word by word
`timescale 1ns/10ps
`default_nettype none
module wsmu_word_alu import wsmu_pkg::*; (
  input  wire logic [1:0]  i_mode,
  input  wire logic [15:0] i_word,
  input  wire logic [3:0]  i_carry,
  output logic [15:0]      o_word,
  output logic [3:0]       o_carry
);
  always_comb begin
    unique case (i_mode)
      ALU_DIGIT_LEFT: begin
        o_word  = {i_word[11:0], i_carry};
        o_carry = i_word[15:12];
      end
      ALU_DIGIT_RIGHT: begin
        o_word  = {i_carry, i_word[15:4]};
        o_carry = i_word[3:0];
      end
      ALU_BIT_LEFT: begin
        o_word  = {i_word[14:0], i_carry[0]};
        o_carry = {3'h0, i_word[15]};
      end
      ALU_BIT_RIGHT: begin
        o_word  = {i_carry[0], i_word[15:1]};
        o_carry = {3'h0, i_word[0]};
      end
    endcase
  end
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench for the word shift and move unit
// assumes the memory model and the bound checker beside it
`timescale 1ns/10ps
`default_nettype none
module tb_top import wsmu_pkg::*;;
  logic        i_ref_clk = 1'h0;
  logic        i_rst = 1'h1, i_start = 1'h0, i_exec_cond = 1'h0;
  logic [7:0]  i_func = 8'h00;
  logic [2:0]  i_opd_a_area = 3'h0;
  logic [9:0]  i_opd_a_off = 10'h000;
  logic        i_opd_a_is_const = 1'h0;
  logic [15:0] i_opd_a_const = 16'h0000;
  logic [2:0]  i_opd_b_area = 3'h0;
  logic [9:0]  i_opd_b_off = 10'h000;
  logic        i_opd_b_ind = 1'h0;
  logic [2:0]  i_opd_c_area = 3'h0;
  logic [9:0]  i_opd_c_off = 10'h000;
  logic [15:0] i_mem_rdata;
  logic        o_busy, o_done, o_mem_rd, o_mem_wr, o_fault_flag, o_carry_bit, o_zero_result_flag;
  logic [2:0]  o_mem_area;
  logic [9:0]  o_mem_off;
  logic [15:0] o_mem_wdata;
  int          errors = 0;
  int          checked = 0;
  int          cycles = 0;
  wsmu_core dut (.i_ref_clk, .i_rst, .i_start, .i_exec_cond, .i_func, .i_opd_a_area, .i_opd_a_off,
    .i_opd_a_ind(1'h0), .i_opd_a_is_const, .i_opd_a_const, .i_opd_b_area, .i_opd_b_off, .i_opd_b_ind,
    .i_opd_c_area, .i_opd_c_off, .i_opd_c_ind(1'h0), .i_mem_rdata, .o_busy, .o_done, .o_mem_rd, .o_mem_wr,
    .o_mem_area, .o_mem_off, .o_mem_wdata, .o_fault_flag, .o_carry_bit, .o_zero_result_flag);
  wsmu_mem_model mem (.i_ref_clk, .i_rd(o_mem_rd), .i_wr(o_mem_wr), .i_area(o_mem_area), .i_off(o_mem_off),
    .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
  initial begin
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  // hang guard
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      $display("ERROR %0t run did not finish", $time);
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkf(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chkw(input logic [12:0] a, input logic [15:0] exp);
    chk(mem.words[a], exp);
  endtask
  task automatic put(input logic [12:0] a, input logic [15:0] v);
    mem.words[a] = v;
  endtask
  // address: area over offset
  task automatic run(input logic [7:0] f, input logic c, k, input logic [15:0] v, input logic [12:0] a, b, e);
    int n;
    @(posedge i_ref_clk);
    i_start <= 1'h1;
    i_exec_cond <= c;
    i_func <= f;
    i_opd_a_is_const <= k;
    i_opd_a_const <= v;
    {i_opd_a_area, i_opd_a_off} <= a;
    {i_opd_b_area, i_opd_b_off} <= b;
    {i_opd_c_area, i_opd_c_off} <= e;
    @(posedge i_ref_clk);
    i_start <= 1'h0;
    n = 0;
    do begin
      @(negedge i_ref_clk);
      n++;
    end while (o_done !== 1'h1 && n < 80);
    if (n == 80) chkf(o_done, 1'h1);
    @(negedge i_ref_clk);
  endtask
  task automatic rng(input logic [7:0] f, input logic [12:0] b, e);
    run(f, 1'h1, 1'h0, 16'h0000, 13'h0000, b, e);
  endtask
  task automatic t_digit;
    put(13'h1005, 16'h1234);
    put(13'h1006, 16'h5678);
    put(13'h1007, 16'h9999);
    rng(FN_DIGIT_SHIFT_LEFT, 13'h1005, 13'h1006);
    chkw(13'h1005, 16'h2340);
    chkw(13'h1006, 16'h6781);
    chkw(13'h1007, 16'h9999);
    put(13'h1005, 16'h1234);
    put(13'h1006, 16'h5678);
    rng(FN_DIGIT_SHIFT_RIGHT, 13'h1005, 13'h1006);
    chkw(13'h1005, 16'h0123);
    chkw(13'h1006, 16'h4567);
    chkf(o_fault_flag, 1'h0);
  endtask
  task automatic t_fault;
    int w;
    rng(FN_DIGIT_SHIFT_LEFT, 13'h1006, 13'h1005);
    chkf(o_fault_flag, 1'h1);
    chkw(13'h1006, 16'h4567);
    rng(FN_DIGIT_SHIFT_RIGHT, 13'h1005, 13'h1406);
    chkf(o_fault_flag, 1'h1);
    run(FN_REV_SHIFT_REGISTER, 1'h1, 1'h1, 16'h7000, 13'h0000, 13'h1400, 13'h0c01);
    chkf(o_fault_flag, 1'h1);
    run(FN_BLOCK_FILL, 1'h1, 1'h1, 16'h1111, 13'h0000, 13'h0c06, 13'h0c05);
    chkf(o_fault_flag, 1'h1);
    run(FN_BLOCK_COPY, 1'h1, 1'h1, 16'h00a1, 13'h0000, 13'h0c1e, 13'h0c28);
    chkf(o_fault_flag, 1'h1);
    run(FN_BLOCK_COPY, 1'h1, 1'h1, 16'h0003, 13'h0000, 13'h0fe6, 13'h0c28);
    chkf(o_fault_flag, 1'h1);
    w = mem.wr_cnt;
    run(FN_DIGIT_SHIFT_LEFT, 1'h0, 1'h0, 16'h0000, 13'h0000, 13'h1005, 13'h1006);
    chkf(o_fault_flag, 1'h1);
    chkw(13'h1005, 16'h0123);
    chk(16'(mem.wr_cnt - w), 16'h0000);
  endtask
  task automatic t_sreg;
    put(13'h0000, 16'h7000);
    put(13'h1402, 16'h8000);
    rng(FN_REV_SHIFT_REGISTER, 13'h1402, 13'h1402);
    chkw(13'h1402, 16'h0001);
    chkf(o_carry_bit, 1'h1);
    put(13'h1400, 16'h8001);
    put(13'h1401, 16'h0000);
    rng(FN_REV_SHIFT_REGISTER, 13'h1400, 13'h1401);
    chkw(13'h1400, 16'h0003);
    chkw(13'h1401, 16'h0001);
    chkf(o_carry_bit, 1'h0);
    put(13'h0000, 16'h6000);
    rng(FN_REV_SHIFT_REGISTER, 13'h1400, 13'h1401);
    chkw(13'h1400, 16'h8001);
    chkw(13'h1401, 16'h8000);
    chkf(o_carry_bit, 1'h1);
    put(13'h0000, 16'h3000);
    rng(FN_REV_SHIFT_REGISTER, 13'h1400, 13'h1401);
    chkw(13'h1400, 16'h8001);
    put(13'h0000, 16'hc000);
    rng(FN_REV_SHIFT_REGISTER, 13'h1400, 13'h1401);
    chkw(13'h1400, 16'h0000);
    chkw(13'h1401, 16'h0000);
  endtask
  task automatic t_copy;
    put(13'h0c15, 16'h0000);
    run(FN_WORD_COPY_INVERTED, 1'h1, 1'h1, 16'h00ff, 13'h0000, 13'h0c14, 13'h0000);
    chkw(13'h0c14, 16'hff00);
    chkf(o_zero_result_flag, 1'h0);
    run(FN_WORD_COPY, 1'h1, 1'h0, 16'h0000, 13'h0c15, 13'h0c16, 13'h0000);
    chkw(13'h0c16, 16'h0000);
    chkf(o_zero_result_flag, 1'h1);
    run(FN_WORD_COPY_INVERTED, 1'h1, 1'h0, 16'h0000, 13'h0c15, 13'h0c14, 13'h0000);
    chkw(13'h0c14, 16'hffff);
    chkw(13'h0c15, 16'h0000);
  endtask
  task automatic t_tc;
    put(13'h1803, 16'h0100);
    run(FN_WORD_COPY, 1'h1, 1'h1, 16'h1111, 13'h0000, 13'h1803, 13'h0000);
    chkw(13'h1803, 16'h0100);
    chkf(o_fault_flag, 1'h1);
    run(FN_BLOCK_FILL, 1'h1, 1'h1, 16'h0250, 13'h0000, 13'h1803, 13'h1804);
    chkw(13'h1803, 16'h0250);
    chkw(13'h1804, 16'h0250);
    chkf(o_fault_flag, 1'h0);
  endtask
  task automatic t_block_copy;
    for (int i = 0; i < 3; i++) begin
      put(13'h0c1e + 13'(i), 16'h1111 * 16'(i + 1));
    end
    run(FN_BLOCK_COPY, 1'h1, 1'h1, 16'h0003, 13'h0000, 13'h0c1e, 13'h0c28);
    for (int i = 0; i < 3; i++) begin
      chkw(13'h0c28 + 13'(i), 16'h1111 * 16'(i + 1));
    end
    chkw(13'h0c1e, 16'h1111);
  endtask
  task automatic t_ind;
    put(13'h0c32, 16'h0060);
    @(posedge i_ref_clk);
    i_opd_b_ind <= 1'h1;
    run(FN_WORD_COPY, 1'h1, 1'h1, 16'habcd, 13'h0000, 13'h0c32, 13'h0000);
    chkw(13'h0c3c, 16'habcd);
    chkf(o_fault_flag, 1'h0);
    put(13'h0c32, 16'h00a0);
    run(FN_WORD_COPY, 1'h1, 1'h1, 16'habcd, 13'h0000, 13'h0c32, 13'h0000);
    chkf(o_fault_flag, 1'h1);
    put(13'h0c32, 16'h1000);
    run(FN_WORD_COPY, 1'h1, 1'h1, 16'habcd, 13'h0000, 13'h0c32, 13'h0000);
    chkf(o_fault_flag, 1'h1);
    @(posedge i_ref_clk);
    i_opd_b_ind <= 1'h0;
  endtask
  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'h0;
    t_digit();
    t_fault();
    t_sreg();
    t_copy();
    t_tc();
    t_block_copy();
    t_ind();
    print_verdict();
  end
endmodule
`default_nettype wire

// ### testbench/wsmu_mem_model.sv
// data area word store standing in for the controller memory
// assumes one-cycle read latency and single-cycle strobes
`timescale 1ns/10ps
`default_nettype none
module wsmu_mem_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [2:0]  i_area,
  input  wire logic [9:0]  i_off,
  input  wire logic [15:0] i_wdata,
  output logic [15:0]      o_rdata
);
  logic [15:0] words [0:8191];
  int          wr_cnt = 0;
  initial o_rdata = 16'h5a5a;
  // idle bus flips: stale word never passes
  always @(posedge i_ref_clk) begin
    o_rdata <= i_rd ? words[{i_area, i_off}] : ~o_rdata;
    if (i_wr) begin
      words[{i_area, i_off}] <= i_wdata;
      wr_cnt++;
    end
  end
endmodule
`default_nettype wire

// ### testbench/wsmu_props.sv
// assertions on the word shift and move unit top ports
// assumes the bench holds operands steady while busy
`timescale 1ns/10ps
`default_nettype none
module wsmu_props import wsmu_pkg::*; (
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        i_start,
  input wire logic        i_exec_cond,
  input wire logic [7:0]  i_func,
  input wire logic        i_opd_a_is_const,
  input wire logic [15:0] i_opd_a_const,
  input wire logic [2:0]  i_opd_b_area,
  input wire logic        i_opd_b_ind,
  input wire logic [2:0]  i_opd_c_area,
  input wire logic        i_opd_c_ind,
  input wire logic [15:0] i_mem_rdata,
  input wire logic        o_busy,
  input wire logic        o_done,
  input wire logic        o_mem_rd,
  input wire logic        o_mem_wr,
  input wire logic [2:0]  o_mem_area,
  input wire logic [15:0] o_mem_wdata,
  input wire logic        o_fault_flag,
  input wire logic        o_carry_bit,
  input wire logic        o_zero_result_flag
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  logic [15:0] last_wdata;
  wire logic take = i_start && !o_busy;
  wire logic no_ind = !i_opd_b_ind && !i_opd_c_ind;
  wire logic is_copy = i_func == FN_WORD_COPY || i_func == FN_WORD_COPY_INVERTED;
  wire logic ranged = i_func == FN_DIGIT_SHIFT_LEFT || i_func == FN_REV_SHIFT_REGISTER || i_func == FN_BLOCK_FILL;
  // zero flag judged after done
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      last_wdata <= 16'h0000;
    end else if (o_mem_wr) begin
      last_wdata <= o_mem_wdata;
    end
  end
  AST_OFF_IDLE: assert property (take && !i_exec_cond |=> o_done && !o_mem_rd && !o_mem_wr)
    else $error("off: memory used");
  AST_OFF_FLAGS: assert property (take && !i_exec_cond |=> $stable({o_fault_flag, o_carry_bit, o_zero_result_flag}))
    else $error("off: flags moved");
  AST_DSL_DATA: assert property (o_mem_rd && no_ind && i_func == FN_DIGIT_SHIFT_LEFT
    |=> ##1 o_mem_wr && o_mem_wdata[15:4] == $past(i_mem_rdata[11:0])) else $error("left shift data");
  AST_DSR_DATA: assert property (o_mem_rd && no_ind && i_func == FN_DIGIT_SHIFT_RIGHT
    |=> ##1 o_mem_wr && o_mem_wdata[11:0] == $past(i_mem_rdata[15:4])) else $error("right shift data");
  AST_COPY_DATA: assert property (o_mem_wr && i_opd_a_is_const && i_func == FN_WORD_COPY
    |-> o_mem_wdata == i_opd_a_const) else $error("copy data");
  AST_COPYN_DATA: assert property (o_mem_wr && i_opd_a_is_const && i_func == FN_WORD_COPY_INVERTED
    |-> o_mem_wdata == ~i_opd_a_const) else $error("inverted data");
  AST_ZERO_FLAG: assert property (o_done && is_copy && i_exec_cond
    |=> o_fault_flag || (o_zero_result_flag == (last_wdata == 16'h0000))) else $error("zero flag");
  AST_NO_TC_COPY: assert property (o_mem_wr && is_copy |-> o_mem_area != AREA_TC)
    else $error("timer copy written");
  AST_BLOCK_COPY_DEST: assert property (o_mem_wr && no_ind && i_func == FN_BLOCK_COPY |-> o_mem_area == i_opd_c_area)
    else $error("copy outside dest");
  AST_SPLIT_FAULT: assert property (take && i_exec_cond && no_ind && ranged && i_opd_b_area != i_opd_c_area
    |=> (!o_mem_wr throughout (##[0:40] o_done)) ##1 o_fault_flag) else $error("split not refused");
  cover property (o_mem_wr && i_func == FN_DIGIT_SHIFT_LEFT);
  cover property ($rose(o_carry_bit));
  cover property ($rose(o_fault_flag));
endmodule
bind wsmu_core wsmu_props u_props (.i_ref_clk, .i_rst, .i_start, .i_exec_cond, .i_func, .i_opd_a_is_const,
  .i_opd_a_const, .i_opd_b_area, .i_opd_b_ind, .i_opd_c_area, .i_opd_c_ind, .i_mem_rdata, .o_busy, .o_done,
  .o_mem_rd, .o_mem_wr, .o_mem_area, .o_mem_wdata, .o_fault_flag, .o_carry_bit, .o_zero_result_flag);
`default_nettype wire
